// *** logic/mei_pkg.sv ***
package mei_pkg;
	// register offsets
	localparam logic [7:0] A_TAP_THR    = 8'h1d;
	localparam logic [7:0] A_TAP_DUR    = 8'h21;
	localparam logic [7:0] A_TAP_LAT    = 8'h22;
	localparam logic [7:0] A_TAP_WIN    = 8'h23;
	localparam logic [7:0] A_ACT_THR    = 8'h24;
	localparam logic [7:0] A_INACT_THR  = 8'h25;
	localparam logic [7:0] A_INACT_TIME = 8'h26;
	localparam logic [7:0] A_AXIS_SEL   = 8'h27;
	localparam logic [7:0] A_FF_THR     = 8'h28;
	localparam logic [7:0] A_FF_TIME    = 8'h29;
	localparam logic [7:0] A_IRQ_EN     = 8'h2e;
	localparam logic [7:0] A_IRQ_ROUTE  = 8'h2f;
	localparam logic [7:0] A_IRQ_FLAGS  = 8'h30;
	localparam logic [7:0] A_FMT        = 8'h31;
	localparam logic [7:0] A_DATA_FIRST = 8'h32;
	localparam logic [7:0] A_DATA_LAST  = 8'h37;
	localparam logic [7:0] A_BUF_CTL    = 8'h38;
	localparam logic [7:0] A_BUF_STAT   = 8'h39;
	localparam logic [7:0] REG_RESET    = 8'h00;
	// field positions
	localparam int FMT_INVERT  = 5;
	localparam int BUF_MODE_LO = 6;
	localparam int BUF_TRIG    = 5;
	localparam int AXIS_ACT_LO = 4;
	localparam int MAG_LSB     = 7;
	// flag bit positions in irq_flags
	localparam int F_READY  = 7;
	localparam int F_STAP   = 6;
	localparam int F_DTAP   = 5;
	localparam int F_ACT    = 4;
	localparam int F_INACT  = 3;
	localparam int F_FFALL  = 2;
	localparam int F_WMARK  = 1;
	localparam int F_OVR    = 0;
	localparam logic [5:0] BUF_DEPTH = 6'h20;

	typedef enum logic [1:0] {
		MODE_BYPASS = 2'h0,
		MODE_FIFO   = 2'h1,
		MODE_STREAM = 2'h2,
		MODE_TRIG   = 2'h3
	} mei_mode_type;

	typedef enum logic [3:0] {
		TAP_IDLE   = 4'h1,
		TAP_ABOVE  = 4'h2,
		TAP_LATENT = 4'h4,
		TAP_WINDOW = 4'h8
	} mei_tap_state_type;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mei_sample_type;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mei_req_type;
endpackage

// *** logic/mei_motion_irq.sv ***
`timescale 1ns/1ps
module mei_motion_irq (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    link_clk,
	input  wire logic                    smp_valid,
	input  wire mei_pkg::mei_sample_type smp,
	input  wire logic                    lk_req,
	input  wire logic                    lk_wr,
	input  wire logic [7:0]              lk_addr,
	input  wire logic [7:0]              lk_wdata,
	output logic                         lk_busy,
	output logic                         lk_ack,
	output logic [7:0]                   lk_rdata,
	output logic                         irq_pin_a,
	output logic                         irq_pin_b
);
	// ****************************************
	// link side: request capture, answer return
	// ****************************************
	logic [1:0]           lk_rst_sync;
	logic                 lk_rst;
	logic                 req_tgl;
	logic                 ack_tgl;
	logic [2:0]           ack_sync;
	logic [2:0]           req_sync;
	logic [7:0]           rd_hold;
	mei_pkg::mei_req_type req_hold;
	wire                  ack_edge = ack_sync[1] ^ ack_sync[2];

	assign lk_rst = lk_rst_sync[1];
	always_ff @(posedge link_clk) begin
		lk_rst_sync <= {lk_rst_sync[0], rst};
	end

	always_ff @(posedge link_clk) begin
		if (lk_rst) begin
			ack_sync <= 3'h0;
		end else begin
			ack_sync <= {ack_sync[1:0], ack_tgl};
		end
	end

	// req_hold stays put while busy, so the core reads it safely
	always_ff @(posedge link_clk) begin
		if (lk_rst) begin
			req_tgl  <= 1'b0;
			lk_busy  <= 1'b0;
			lk_ack   <= 1'b0;
			lk_rdata <= 8'h00;
			req_hold <= '0;
		end else begin
			lk_ack <= ack_edge;
			if (ack_edge) begin
				lk_busy  <= 1'b0;
				lk_rdata <= rd_hold;
			end else if (lk_req && !lk_busy) begin
				lk_busy  <= 1'b1;
				req_tgl  <= ~req_tgl;
				req_hold <= '{wr: lk_wr, addr: lk_addr, wdata: lk_wdata};
			end
		end
	end

	// ****************************************
	// core side: access decode
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_sync <= 3'h0;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
		end
	end

	wire       acc      = req_sync[1] ^ req_sync[2];
	wire       wr_en    = acc && req_hold.wr;
	wire       rd_en    = acc && !req_hold.wr;
	wire [7:0] addr     = req_hold.addr;
	wire       rd_flags = rd_en && (addr == mei_pkg::A_IRQ_FLAGS);
	wire       rd_last  = rd_en && (addr == mei_pkg::A_DATA_LAST);

	logic [7:0] tap_threshold, tap_duration, tap_latency, tap_window;
	logic [7:0] activity_threshold, inactivity_threshold, inactivity_time;
	logic [7:0] motion_axis_select, freefall_threshold, freefall_time;
	logic [7:0] irq_enable, irq_pin_route, output_format_config;
	logic [7:0] sample_buffer_control;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tap_threshold         <= mei_pkg::REG_RESET;
			tap_duration          <= mei_pkg::REG_RESET;
			tap_latency           <= mei_pkg::REG_RESET;
			tap_window            <= mei_pkg::REG_RESET;
			activity_threshold    <= mei_pkg::REG_RESET;
			inactivity_threshold  <= mei_pkg::REG_RESET;
			inactivity_time       <= mei_pkg::REG_RESET;
			motion_axis_select    <= mei_pkg::REG_RESET;
			freefall_threshold    <= mei_pkg::REG_RESET;
			freefall_time         <= mei_pkg::REG_RESET;
			irq_enable            <= mei_pkg::REG_RESET;
			irq_pin_route         <= mei_pkg::REG_RESET;
			output_format_config  <= mei_pkg::REG_RESET;
			sample_buffer_control <= mei_pkg::REG_RESET;
		end else if (wr_en) begin
			case (addr)
				mei_pkg::A_TAP_THR:    tap_threshold         <= req_hold.wdata;
				mei_pkg::A_TAP_DUR:    tap_duration          <= req_hold.wdata;
				mei_pkg::A_TAP_LAT:    tap_latency           <= req_hold.wdata;
				mei_pkg::A_TAP_WIN:    tap_window            <= req_hold.wdata;
				mei_pkg::A_ACT_THR:    activity_threshold    <= req_hold.wdata;
				mei_pkg::A_INACT_THR:  inactivity_threshold  <= req_hold.wdata;
				mei_pkg::A_INACT_TIME: inactivity_time       <= req_hold.wdata;
				mei_pkg::A_AXIS_SEL:   motion_axis_select    <= req_hold.wdata;
				mei_pkg::A_FF_THR:     freefall_threshold    <= req_hold.wdata;
				mei_pkg::A_FF_TIME:    freefall_time         <= req_hold.wdata;
				mei_pkg::A_IRQ_EN:     irq_enable            <= req_hold.wdata;
				mei_pkg::A_IRQ_ROUTE:  irq_pin_route         <= req_hold.wdata;
				mei_pkg::A_FMT:        output_format_config  <= req_hold.wdata;
				mei_pkg::A_BUF_CTL:    sample_buffer_control <= req_hold.wdata;
				default: ;
			endcase
		end
	end

	wire mei_pkg::mei_mode_type mode =
		mei_pkg::mei_mode_type'(sample_buffer_control[mei_pkg::BUF_MODE_LO +: 2]);
	wire [4:0] keep_n  = sample_buffer_control[4:0];
	wire       bypass  = (mode == mei_pkg::MODE_BYPASS);

	// ****************************************
	// detectors
	// ****************************************
	function automatic logic [7:0] mag(input logic signed [15:0] s);
		logic [15:0] a;
		a = s[15] ? 16'(-s) : 16'(s);
		return a[mei_pkg::MAG_LSB +: 8];
	endfunction

	wire [7:0] mx = mag(smp.x);
	wire [7:0] my = mag(smp.y);
	wire [7:0] mz = mag(smp.z);
	wire [2:0] act_sel   = motion_axis_select[mei_pkg::AXIS_ACT_LO +: 3];
	wire [2:0] inact_sel = motion_axis_select[2:0];
	wire [2:0] over_act  = {mx > activity_threshold, my > activity_threshold,
		mz > activity_threshold};
	wire [2:0] under_in  = {mx < inactivity_threshold, my < inactivity_threshold,
		mz < inactivity_threshold};
	wire       tap_above = (mx > tap_threshold) || (my > tap_threshold)
		|| (mz > tap_threshold);
	wire       act_evt   = smp_valid && |(over_act & act_sel);
	wire       inact_low = (inact_sel != 3'h0) && ((under_in | ~inact_sel) == 3'h7);
	wire       ff_low    = (mx < freefall_threshold) && (my < freefall_threshold)
		&& (mz < freefall_threshold);

	logic [7:0] inact_cnt, ff_cnt;
	// counted in samples; event fires once per quiet stretch, or on every sample from then on when the time is 8'hff
	wire inact_evt = smp_valid && inact_low && (inact_cnt == inactivity_time);
	wire ff_evt    = smp_valid && ff_low && (ff_cnt == freefall_time);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			inact_cnt <= 8'h00;
			ff_cnt    <= 8'h00;
		end else if (smp_valid) begin
			inact_cnt <= !inact_low ? 8'h00 : inact_cnt + {7'h0, inact_cnt != 8'hff};
			ff_cnt    <= !ff_low ? 8'h00 : ff_cnt + {7'h0, ff_cnt != 8'hff};
		end
	end

	mei_pkg::mei_tap_state_type tap_st;
	logic [7:0] tap_cnt;
	logic       second;
	wire        tap_ok = (tap_cnt < tap_duration);
	wire        stap_evt = smp_valid && (tap_st == mei_pkg::TAP_ABOVE) && !tap_above
		&& tap_ok && !second;
	wire        dtap_evt = smp_valid && (tap_st == mei_pkg::TAP_ABOVE) && !tap_above
		&& tap_ok && second;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tap_st  <= mei_pkg::TAP_IDLE;
			tap_cnt <= 8'h00;
			second  <= 1'b0;
		end else if (smp_valid) begin
			case (tap_st)
				mei_pkg::TAP_IDLE: begin
					second  <= 1'b0;
					tap_cnt <= 8'h01;
					if (tap_above) tap_st <= mei_pkg::TAP_ABOVE;
				end
				mei_pkg::TAP_ABOVE: begin
					if (tap_above) begin
						tap_cnt <= tap_cnt + {7'h0, tap_cnt != 8'hff};
					end else begin
						tap_cnt <= 8'h01;
						tap_st  <= (tap_ok && !second && tap_window != 8'h00) ?
							mei_pkg::TAP_LATENT : mei_pkg::TAP_IDLE;
					end
				end
				mei_pkg::TAP_LATENT: begin
					tap_cnt <= tap_cnt + 8'h01;
					if (tap_above) tap_st <= mei_pkg::TAP_IDLE;
					else if (tap_cnt >= tap_latency) begin
						tap_st  <= mei_pkg::TAP_WINDOW;
						tap_cnt <= 8'h01;
					end
				end
				mei_pkg::TAP_WINDOW: begin
					tap_cnt <= tap_cnt + 8'h01;
					if (tap_above) begin
						tap_st  <= mei_pkg::TAP_ABOVE;
						second  <= 1'b1;
						tap_cnt <= 8'h01;
					end else if (tap_cnt >= tap_window) tap_st <= mei_pkg::TAP_IDLE;
				end
				default: tap_st <= mei_pkg::TAP_IDLE;
			endcase
		end
	end

	// ****************************************
	// sample buffer and data registers
	// ****************************************
	mei_pkg::mei_sample_type mem [32];
	mei_pkg::mei_sample_type out_reg;
	logic [4:0] wr_ptr, rd_ptr;
	logic [5:0] count;
	logic       trig_done, unread, ovr, trig_prev;
	wire        full = (count == mei_pkg::BUF_DEPTH);
	wire        pop  = rd_last && !bypass && (count != 6'h00);
	// fifo stops when full, stream and pre-trigger wrap
	wire        push = smp_valid && !bypass && (!full || mode == mei_pkg::MODE_STREAM
		|| (mode == mei_pkg::MODE_TRIG && !trig_done));
	wire        drop = push && full && !pop;
	logic       pin_a_raw, pin_b_raw;
	wire        trig_lvl = sample_buffer_control[mei_pkg::BUF_TRIG] ? pin_b_raw : pin_a_raw;
	wire        trig_evt = (mode == mei_pkg::MODE_TRIG) && !trig_done && trig_lvl
		&& !trig_prev;
	wire        trim = count > {1'b0, keep_n};

	always_ff @(posedge core_clk) begin
		if (push) mem[wr_ptr] <= smp;
	end

	always_ff @(posedge core_clk) begin
		if (rst || bypass) begin
			wr_ptr    <= 5'h00;
			rd_ptr    <= 5'h00;
			count     <= 6'h00;
			trig_done <= 1'b0;
		end else if (trig_evt) begin
			trig_done <= 1'b1;
			if (trim) begin
				rd_ptr <= wr_ptr - keep_n;
				count  <= {1'b0, keep_n};
			end
		end else begin
			if (push) wr_ptr <= wr_ptr + 5'h01;
			if (pop || drop) rd_ptr <= rd_ptr + 5'h01;
			if (push && !pop && !full) count <= count + 6'h01;
			else if (pop && !push) count <= count - 6'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_reg   <= '0;
			unread    <= 1'b0;
			ovr       <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trig_lvl;
			if (bypass && smp_valid) out_reg <= smp;
			else if (pop) out_reg <= mem[rd_ptr];
			// set wins over the clearing read
			unread <= (bypass && smp_valid) || (unread && !rd_last && bypass);
			if ((bypass && smp_valid && unread) || drop
				|| (push && !pop && count == mei_pkg::BUF_DEPTH - 6'h01)) ovr <= 1'b1;
			else if (pop || (bypass && rd_last)) ovr <= 1'b0;
		end
	end

	// ****************************************
	// flags, routing and pins
	// ****************************************
	logic [4:0] sticky;
	wire  [4:0] sticky_set = {stap_evt, dtap_evt, act_evt, inact_evt, ff_evt};
	wire        ready = bypass ? unread : (count != 6'h00);
	// level while count at or above samples field
	wire        wmark = !bypass && (count >= {1'b0, keep_n});
	wire  [7:0] flags = {ready, sticky, wmark, ovr};
	wire  [7:0] live  = flags & irq_enable;
	wire        inv   = output_format_config[mei_pkg::FMT_INVERT];

	assign pin_a_raw = |(live & ~irq_pin_route);
	assign pin_b_raw = |(live & irq_pin_route);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sticky    <= 5'h00;
			irq_pin_a <= 1'b0;
			irq_pin_b <= 1'b0;
		end else begin
			// source read clears, new event wins
			sticky    <= (sticky & {5{!rd_flags}}) | sticky_set;
			irq_pin_a <= pin_a_raw ^ inv;
			irq_pin_b <= pin_b_raw ^ inv;
		end
	end

	// outside bypass the data registers show the oldest buffered sample
	wire mei_pkg::mei_sample_type data_src = bypass ? out_reg : mem[rd_ptr];
	wire [2:0] byte_idx = 3'(addr - mei_pkg::A_DATA_FIRST);
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		case (addr)
			mei_pkg::A_TAP_THR:    rd_val = tap_threshold;
			mei_pkg::A_TAP_DUR:    rd_val = tap_duration;
			mei_pkg::A_TAP_LAT:    rd_val = tap_latency;
			mei_pkg::A_TAP_WIN:    rd_val = tap_window;
			mei_pkg::A_ACT_THR:    rd_val = activity_threshold;
			mei_pkg::A_INACT_THR:  rd_val = inactivity_threshold;
			mei_pkg::A_INACT_TIME: rd_val = inactivity_time;
			mei_pkg::A_AXIS_SEL:   rd_val = motion_axis_select;
			mei_pkg::A_FF_THR:     rd_val = freefall_threshold;
			mei_pkg::A_FF_TIME:    rd_val = freefall_time;
			mei_pkg::A_IRQ_EN:     rd_val = irq_enable;
			mei_pkg::A_IRQ_ROUTE:  rd_val = irq_pin_route;
			mei_pkg::A_IRQ_FLAGS:  rd_val = flags;
			mei_pkg::A_FMT:        rd_val = output_format_config;
			mei_pkg::A_BUF_CTL:    rd_val = sample_buffer_control;
			mei_pkg::A_BUF_STAT:   rd_val = {trig_done, 1'b0, count};
			8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37:
				rd_val = data_src[(2 - int'(byte_idx[2:1])) * 16 + int'(byte_idx[0]) * 8 +: 8];
			default: rd_val = 8'h00;
		endcase
	end

	// byte order: x low, x high, y low, y high, z low, z high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_tgl <= 1'b0;
			rd_hold <= 8'h00;
		end else if (acc) begin
			ack_tgl <= ~ack_tgl;
			if (!req_hold.wr) rd_hold <= {rd_val[7:0]};
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_pin_polarity: assert property (##1 irq_pin_a == ($past(pin_a_raw) ^ $past(inv)))
		else $error("pin a level disagrees with flags and polarity");
	chk_irq_gating: assert property ((irq_enable == 8'h00) |=> irq_pin_b == $past(inv))
		else $error("disabled interrupt reached pin");
	chk_route_b: assert property ((live & irq_pin_route) != 8'h00 |=> irq_pin_b != $past(inv))
		else $error("routed flag missing on pin b");
	chk_src_clear: assert property (rd_flags && sticky_set == 5'h00 |=> sticky == 5'h00)
		else $error("source read left a flag set");
	chk_ready_set: assert property (bypass && smp_valid && $stable(mode) |=> ready)
		else $error("new sample did not raise ready");
	chk_ovr_full: assert property (!bypass && push && full && !pop && !trig_evt |=> ovr)
		else $error("overrun missed on full buffer");
	chk_bypass_empty: assert property (bypass |=> count == 6'h00)
		else $error("buffer not empty in bypass");
	chk_fifo_stop: assert property (mode == mei_pkg::MODE_FIFO && full && !pop
		&& $stable(mode) |=> full && $stable(wr_ptr))
		else $error("fifo mode stored past full");
	chk_stream_keep: assert property (mode == mei_pkg::MODE_STREAM && full && smp_valid
		&& !pop |=> full && rd_ptr == $past(rd_ptr) + 5'h01)
		else $error("stream did not drop oldest");
	chk_trig_keep: assert property (trig_evt && trim |=> count == {1'b0, $past(keep_n)})
		else $error("trigger kept wrong sample count");
	chk_trig_once: assert property (trig_done && mode == mei_pkg::MODE_TRIG
		|=> trig_done || bypass)
		else $error("trigger rearmed without bypass");
	chk_pop_data: assert property (pop && !smp_valid |=> out_reg == $past(mem[rd_ptr]))
		else $error("pop did not load oldest sample");

	cov_double_tap: cover property (dtap_evt);
	cov_trigger: cover property (trig_evt && trim);
	cov_stream_wrap: cover property (drop && mode == mei_pkg::MODE_STREAM);
endmodule // mei_motion_irq

// *** verification/mei_host_model.sv ***
`timescale 1ns/1ps
module mei_host_model (
	input  wire logic       link_clk,
	input  wire logic       lk_busy,
	input  wire logic       lk_ack,
	input  wire logic [7:0] lk_rdata,
	output logic            lk_req,
	output logic            lk_wr,
	output logic [7:0]      lk_addr,
	output logic [7:0]      lk_wdata
);
	initial begin
		lk_req = 1'b0;
		lk_wr = 1'b0;
		lk_addr = 8'h00;
		lk_wdata = 8'h00;
	end

	// one access at a time; the request stands until the answer is seen or 40 link clocks pass
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
			output logic [7:0] rdata);
		int n;
		@(posedge link_clk);
		#1;
		lk_req = 1'b1;
		lk_wr = wr;
		lk_addr = addr;
		lk_wdata = wdata;
		n = 0;
		do begin
			@(posedge link_clk);
			#1;
			n++;
		end while (lk_ack !== 1'b1 && n < 40);
		rdata = lk_rdata;
		lk_req = 1'b0;
		// released lines show a changed value, not the stale one
		lk_addr = ~addr;
		lk_wdata = ~wdata;
		if (!wr && addr == mei_pkg::A_DATA_LAST) #5000;
	endtask
endmodule // mei_host_model

// *** verification/motion_event_irq_and_sample_fifo_bench.sv ***
`timescale 1ns/1ps
module motion_event_irq_and_sample_fifo_bench;
	typedef struct {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} mei_row_type;

	logic                    core_clk, link_clk, rst, smp_valid;
	logic                    lk_req, lk_wr, lk_busy, lk_ack, irq_pin_a, irq_pin_b;
	logic [7:0]              lk_addr, lk_wdata, lk_rdata, d;
	logic [47:0]             s;
	mei_pkg::mei_sample_type smp;
	int                      miscompares, tests_run;
	mei_row_type             rows [6];

	mei_motion_irq dut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
		.smp_valid(smp_valid), .smp(smp), .lk_req(lk_req), .lk_wr(lk_wr),
		.lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_ack(lk_ack),
		.lk_rdata(lk_rdata), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
	mei_host_model host (.link_clk(link_clk), .lk_busy(lk_busy), .lk_ack(lk_ack),
		.lk_rdata(lk_rdata), .lk_req(lk_req), .lk_wr(lk_wr), .lk_addr(lk_addr),
		.lk_wdata(lk_wdata));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] x;
		host.access(1'b1, a, v, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		host.access(1'b0, a, 8'h00, v);
	endtask
	function automatic logic [47:0] mk(input int k);
		return {16'h0000 + 16'(k), 16'h0100 + 16'(k), 16'hff00 - 16'(k)};
	endfunction
	task automatic push(input logic [47:0] v);
		@(posedge core_clk);
		#1;
		smp = v;
		smp_valid = 1'b1;
		@(posedge core_clk);
		#1;
		smp_valid = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	// bytes arrive x lo, x hi, y lo, y hi, z lo, z hi
	task automatic pop(output logic [47:0] v);
		logic [7:0] b;
		for (int i = 0; i < 6; i++) begin
			rd(mei_pkg::A_DATA_FIRST + 8'(i), b);
			v[(2 - i / 2) * 16 + (i % 2) * 8 +: 8] = b;
		end
	endtask
	task automatic test_end(input string name);
		$display("test %s done, mismatches so far %0d", name, miscompares);
	endtask

	initial begin
		#400000;
		miscompares++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		smp_valid = 1'b0;
		smp = '0;
		miscompares = 0;
		tests_run = 0;
		rows = '{'{8'h1d, 8'ha5, 8'ha5}, '{8'h21, 8'h5a, 8'h5a}, '{8'h26, 8'hff, 8'hff},
			'{8'h27, 8'h77, 8'h77}, '{8'h29, 8'h01, 8'h01}, '{8'h01, 8'hc3, 8'h00}};
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge link_clk);
		// reset: pins inactive low
		check("pin a reset", 48'(irq_pin_a), 48'h0);
		rd(mei_pkg::A_IRQ_EN, d);
		check("enable reset", 48'(d), 48'(mei_pkg::REG_RESET));
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			check("register readback", 48'(d), 48'(rows[i].exp));
		end
		test_end("registers");

		wr(mei_pkg::A_IRQ_ROUTE, 8'h00);
		wr(mei_pkg::A_IRQ_EN, 8'h80);
		push(mk(1));
		check("ready pin a", 48'({irq_pin_a, irq_pin_b}), 48'h2);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("ready flag", 48'(d & 8'h80), 48'h80);
		pop(s);
		check("bypass data", s, mk(1));
		check("ready cleared pin", 48'({irq_pin_a, irq_pin_b}), 48'h0);
		wr(mei_pkg::A_FMT, 8'h20);
		repeat (4) @(posedge core_clk);
		#1;
		check("inverted idle", 48'({irq_pin_a, irq_pin_b}), 48'h3);
		push(mk(2));
		check("inverted active", 48'({irq_pin_a, irq_pin_b}), 48'h1);
		wr(mei_pkg::A_IRQ_EN, 8'h00);
		wr(mei_pkg::A_FMT, 8'h00);
		wr(mei_pkg::A_IRQ_ROUTE, 8'h80);
		wr(mei_pkg::A_IRQ_EN, 8'h80);
		repeat (4) @(posedge core_clk);
		#1;
		check("ready pin b", 48'({irq_pin_a, irq_pin_b}), 48'h1);
		push(mk(3));
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("bypass overrun", 48'(d & 8'h01), 48'h01);
		pop(s);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("overrun cleared", 48'(d & 8'h81), 48'h00);
		wr(mei_pkg::A_IRQ_EN, 8'h00);
		test_end("pins");

		// fifo mode, watermark at two
		wr(mei_pkg::A_BUF_CTL, 8'h42);
		for (int k = 0; k < 33; k++)
			push(mk(k));
		rd(mei_pkg::A_BUF_STAT, d);
		check("fifo full count", 48'(d & 8'h3f), 48'(mei_pkg::BUF_DEPTH));
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("full flags", 48'(d & 8'h03), 48'h03);
		pop(s);
		check("fifo oldest", s, mk(0));
		rd(mei_pkg::A_BUF_STAT, d);
		check("fifo after pop", 48'(d & 8'h3f), 48'h1f);
		test_end("fifo");

		wr(mei_pkg::A_BUF_CTL, 8'h00);
		rd(mei_pkg::A_BUF_STAT, d);
		check("bypass empty", 48'(d & 8'h3f), 48'h00);
		wr(mei_pkg::A_BUF_CTL, 8'h80);
		for (int k = 0; k < 34; k++)
			push(mk(k));
		rd(mei_pkg::A_BUF_STAT, d);
		check("stream count", 48'(d & 8'h3f), 48'(mei_pkg::BUF_DEPTH));
		pop(s);
		check("stream newest kept", s, mk(2));
		wr(mei_pkg::A_BUF_CTL, 8'h00);
		test_end("stream");

		wr(mei_pkg::A_ACT_THR, 8'h10);
		wr(mei_pkg::A_AXIS_SEL, 8'h70);
		wr(mei_pkg::A_IRQ_ROUTE, 8'h10);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		wr(mei_pkg::A_IRQ_EN, 8'h10);
		push({16'h1000, 16'h0000, 16'h0000});
		check("activity pin b", 48'({irq_pin_a, irq_pin_b}), 48'h1);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("activity flag", 48'(d & 8'h10), 48'h10);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("activity cleared", 48'(d & 8'h10), 48'h00);
		repeat (4) @(posedge core_clk);
		#1;
		check("activity pin off", 48'(irq_pin_b), 48'h0);
		test_end("activity");

		// one short event above the tap threshold, then quiet
		push({16'h6000, 16'h0000, 16'h0000});
		push(mk(0));
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("single tap", 48'(d & 8'h60), 48'h40);
		// free fall: all axes quiet for longer than one sample
		wr(mei_pkg::A_FF_THR, 8'h05);
		push(mk(0));
		push(mk(0));
		rd(mei_pkg::A_IRQ_FLAGS, d);
		check("free fall", 48'(d & 8'h04), 48'h04);
		test_end("detectors");

		// trigger on activity at pin a, keep one sample
		wr(mei_pkg::A_IRQ_EN, 8'h00);
		wr(mei_pkg::A_IRQ_ROUTE, 8'h00);
		rd(mei_pkg::A_IRQ_FLAGS, d);
		wr(mei_pkg::A_IRQ_EN, 8'h10);
		wr(mei_pkg::A_BUF_CTL, 8'hc1);
		for (int k = 0; k < 4; k++)
			push(mk(k));
		push({16'h1000, 16'h0000, 16'h0000});
		// host waits before reading the buffer
		#5000;
		rd(mei_pkg::A_BUF_STAT, d);
		check("trigger kept n", 48'(d), 48'h81);
		push(mk(7));
		rd(mei_pkg::A_IRQ_FLAGS, d);
		push({16'h1000, 16'h0000, 16'h0000});
		rd(mei_pkg::A_BUF_STAT, d);
		check("second trigger ignored", 48'(d), 48'h83);
		pop(s);
		check("trigger sample kept", s, {16'h1000, 16'h0000, 16'h0000});
		wr(mei_pkg::A_BUF_CTL, 8'h00);
		test_end("trigger");

		// reset in mid-run
		@(posedge core_clk);
		#1;
		rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge link_clk);
		check("pins after reset", 48'({irq_pin_a, irq_pin_b}), 48'h0);
		rd(mei_pkg::A_IRQ_EN, d);
		check("enable after reset", 48'(d), 48'(mei_pkg::REG_RESET));
		rd(mei_pkg::A_BUF_STAT, d);
		check("buffer after reset", 48'(d), 48'h00);
		test_end("reset");
		finish_test();
	end
endmodule // motion_event_irq_and_sample_fifo_bench
